// [rtl/stp_link.sv]
`timescale 1ns/10ps
module stp_link
    import stp_pkg::*;
(
    input logic sck,
    input logic select_strobe_n,
    input logic serial_in,
    input logic [15:0] diag_short,
    input logic [15:0] diag_step,
    output logic serial_out,
    output logic serial_out_oe,
    output logic [15:0] cap_word,
    output logic [4:0] cap_count
);

    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic step_sel_r;
    logic step_sel_nxt;
    logic [15:0] shift_r;
    logic [15:0] shift_nxt;
    logic tx_r;
    logic tx_nxt;
    logic tx_live_r;
    logic [15:0] tx_word;
    logic [3:0] tx_idx;
    logic [15:0] cap_word_r;
    logic [4:0] cap_count_r;

    always_comb
    begin
        // saturate so a long frame stays marked as too long
        cnt_nxt = (cnt_r == STP_CNT_OVER) ? cnt_r : cnt_r + 5'h01;
        shift_nxt = {shift_r[14:0], serial_in}; // [R1] [R3]
        step_sel_nxt = step_sel_r;
        if (cnt_r == STP_CNT_SEL_DONE)
        begin
            step_sel_nxt = !shift_r[0] && serial_in; // [R8]
        end
    end

    // strobe high holds the frame logic cleared and deaf to sck
    always_ff @(posedge sck or posedge select_strobe_n)
    begin
        if (select_strobe_n)
        begin
            cnt_r <= '0; // [R2]
            step_sel_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            step_sel_r <= step_sel_nxt;
        end
    end

    always_ff @(posedge sck)
    begin
        if (!select_strobe_n)
        begin
            shift_r <= shift_nxt; // [R1]
        end
    end

    always_comb
    begin
        tx_word = step_sel_r ? diag_step : diag_short; // [R8] [R9]
        tx_idx = STP_TOP_BIT - cnt_r[3:0];
        tx_nxt = (cnt_r < STP_BITS_PER_WORD) ? tx_word[tx_idx] : 1'b0;
    end

    // bits change on the falling edge, stable for the master's rise
    always_ff @(negedge sck or posedge select_strobe_n)
    begin
        if (select_strobe_n)
        begin
            tx_r <= 1'b0;
            tx_live_r <= 1'b0;
        end
        else
        begin
            tx_r <= tx_nxt; // [R10] [R21]
            tx_live_r <= 1'b1;
        end
    end

    // old count and word are sampled before the async clear lands
    always_ff @(posedge select_strobe_n)
    begin
        cap_word_r <= shift_r; // [R4]
        cap_count_r <= cnt_r;
    end

    // flag must show before any sck edge, so this path is not registered
    assign serial_out = tx_live_r ? tx_r : diag_short[STP_FF_BIT]; // [R11]
    assign serial_out_oe = !select_strobe_n; // [R11] [R13]
    assign cap_word = cap_word_r;
    assign cap_count = cap_count_r;

endmodule : stp_link

// [rtl/stp_pkg.sv]
package stp_pkg;

    // serial word framing
    localparam int STP_WORD_W = 16;
    localparam int STP_CNT_W = 5;
    localparam logic [4:0] STP_BITS_PER_WORD = 5'h10;
    localparam logic [4:0] STP_CNT_OVER = 5'h11;
    localparam logic [4:0] STP_CNT_SEL_DONE = 5'h01;
    localparam logic [3:0] STP_TOP_BIT = 4'hf;

    // register select field and codes
    localparam int STP_SEL_HI = 15;
    localparam int STP_SEL_LO = 14;
    localparam int STP_REG_W = 14;
    localparam logic [1:0] STP_SEL_CFG0 = 2'h0;
    localparam logic [1:0] STP_SEL_CFG1 = 2'h1;
    localparam logic [1:0] STP_SEL_RUN = 2'h2;
    localparam logic [1:0] STP_SEL_TBL = 2'h3;

    // power-on values of the writable registers (bits 13..0)
    localparam logic [13:0] STP_CFG0_RST = 14'h271c;
    localparam logic [13:0] STP_CFG1_RST = 14'h1020;
    localparam logic [13:0] STP_RUN_RST = 14'h0520;
    localparam logic [13:0] STP_TBL_RST = 14'h0045;

    // phase table load word
    localparam int STP_PT_ENTRIES = 16;
    localparam int STP_PT_DATA_W = 6;
    localparam int STP_PTP_BIT = 6;

    // diagnostic word layout
    localparam int STP_FF_BIT = 15;
    localparam int STP_SHARED_W = 7;
    localparam int STP_SHORT_W = 8;
    localparam int STP_ANGLE_W = 6;
    localparam logic [6:0] STP_SHARED_RST = 7'h7f;
    localparam logic [7:0] STP_SHORT_RST = 8'hff;
    localparam logic [1:0] STP_ANGLE_PAD = 2'h0;

    // outcome of a frame seen at the strobe's rising edge
    typedef enum logic [3:0] {
        STP_FR_NONE = 4'h1,
        STP_FR_WRITE = 4'h2,
        STP_FR_ERROR = 4'h4,
        STP_FR_POLL = 4'h8
    } stp_frame_t;

endpackage : stp_pkg

// [rtl/stp_port.sv]
`timescale 1ns/10ps
// Operation
// R1 - serial_in shifts into the receive register on each rising sck edge
// R2 - strobe idles high; sck edges are ignored while it is high
// R3 - every word is 16 bits, most significant bit first
// R4 - on strobe rise after 16 edges the addressed register is loaded; the code drops a table word once the phase table is full
// R5 - a good write clears both diagnostic registers as it loads
// R6 - any other nonzero edge count discards the word and sets the summary flag
// R7 - top two bits select one of four writable registers
// R8 - select code 01 shifts out the step-angle diagnostic word
// R9 - every other select code shifts out the short-fault word
// R10 - the chosen diagnostic word shifts out msb first with the input
// R11 - strobe low enables serial_out, showing the summary flag at once
// R12 - strobe low then high with sck held high is a poll, not an error
// R13 - strobe high ends the frame and releases serial_out
// R14 - both diagnostic words share summary and seven status flags on top
// R15 - short-fault low byte holds eight per-switch short flags
// R16 - step-angle low byte holds two zeros and the six-bit angle
// R17 - the master gives each slave its own strobe line
// R18 - without serial access, power-on register values stay in force
// R19 - summary flag is set by any short-fault bit or any error
// R20 - after reset the short-fault word reads all ones
// R21 - serial_out bits change on the falling sck edge
module stp_port
    import stp_pkg::*;
#(
    parameter int PT_ENTRIES = STP_PT_ENTRIES,
    localparam int PT_AW = $clog2(PT_ENTRIES),
    localparam int PT_IW = $clog2(PT_ENTRIES + 1)
)
(
    input logic mclk,
    input logic rstn,
    input logic clk_en,
    input logic sck,
    input logic select_strobe_n,
    input logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input logic thermal_warn_hi,
    input logic thermal_warn_lo,
    input logic overvoltage_flag,
    input logic undervoltage_flag,
    input logic stall_flag,
    input logic open_load_b,
    input logic open_load_a,
    input logic [7:0] short_flags,
    input logic [5:0] step_angle,
    output logic [13:0] system_config,
    output logic [13:0] diag_config,
    output logic [13:0] motor_run_control,
    output logic [13:0] phase_table_load,
    output logic pt_wr,
    output logic [PT_AW-1:0] pt_addr,
    output logic [5:0] pt_data,
    output logic diag_clear,
    output logic fault_summary_flag
);

    // crossing wires
    logic strobe_s;
    logic [15:0] cap_word;
    logic [4:0] cap_count;

    // frame detection
    logic strobe_d_r;
    logic strobe_d_nxt;
    logic frame_end;
    stp_frame_t frame;
    logic [1:0] sel;

    // writable registers
    logic [13:0] cfg0_r;
    logic [13:0] cfg0_nxt;
    logic [13:0] cfg1_r;
    logic [13:0] cfg1_nxt;
    logic [13:0] run_r;
    logic [13:0] run_nxt;
    logic [13:0] tbl_r;
    logic [13:0] tbl_nxt;

    // phase table sequencing
    logic [PT_IW-1:0] pt_idx_r;
    logic [PT_IW-1:0] pt_idx_nxt;
    logic pt_accept;
    logic parity_bad;
    logic pt_wr_r;
    logic pt_wr_nxt;
    logic [PT_AW-1:0] pt_addr_r;
    logic [PT_AW-1:0] pt_addr_nxt;
    logic [5:0] pt_data_r;
    logic [5:0] pt_data_nxt;

    // diagnostics
    logic diag_clr;
    logic [6:0] shared_evt;
    logic [6:0] shared_r;
    logic [6:0] shared_nxt;
    logic [7:0] short_r;
    logic [7:0] short_nxt;
    logic xfer_err_r;
    logic xfer_err_nxt;
    logic parity_err_r;
    logic parity_err_nxt;
    logic ff_r;
    logic ff_nxt;
    logic [5:0] angle_r;
    logic [5:0] angle_nxt;
    logic diag_clear_r;
    logic diag_clear_nxt;
    logic [15:0] word_short;
    logic [15:0] word_step;

    // words the link shifts out; frozen while a frame is open
    logic [15:0] snap_short_r;
    logic [15:0] snap_short_nxt;
    logic [15:0] snap_step_r;
    logic [15:0] snap_step_nxt;

    stp_sync #(
        .W(1),
        .RST(1'b1)
    ) u_strobe_sync (
        .clk(mclk),
        .rstn(rstn),
        .en(clk_en),
        .d(select_strobe_n),
        .q(strobe_s)
    );

    stp_link u_link (
        .sck(sck),
        .select_strobe_n(select_strobe_n),
        .serial_in(serial_in),
        .diag_short(snap_short_r),
        .diag_step(snap_step_r),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe),
        .cap_word(cap_word),
        .cap_count(cap_count)
    );

    // frame outcome: captured word is stable well before strobe_s rises
    always_comb
    begin
        strobe_d_nxt = strobe_s;
        frame_end = strobe_s && !strobe_d_r;
        sel = cap_word[STP_SEL_HI:STP_SEL_LO]; // [R7]
        frame = STP_FR_NONE;
        if (frame_end)
        begin
            if (cap_count == STP_BITS_PER_WORD)
            begin
                frame = STP_FR_WRITE; // [R4]
            end
            else if (cap_count == '0)
            begin
                frame = STP_FR_POLL; // [R12]
            end
            else
            begin
                frame = STP_FR_ERROR; // [R6]
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            strobe_d_r <= 1'b1;
        end
        else if (clk_en)
        begin
            strobe_d_r <= strobe_d_nxt;
        end
    end

    // writable registers; a short or long frame never reaches them
    always_comb
    begin
        cfg0_nxt = cfg0_r;
        cfg1_nxt = cfg1_r;
        run_nxt = run_r;
        tbl_nxt = tbl_r;
        pt_accept = 1'b0;
        if (frame == STP_FR_WRITE)
        begin
            unique case (sel) // [R7]
                STP_SEL_CFG0:
                begin
                    cfg0_nxt = cap_word[STP_REG_W-1:0];
                end
                STP_SEL_CFG1:
                begin
                    cfg1_nxt = cap_word[STP_REG_W-1:0];
                end
                STP_SEL_RUN:
                begin
                    run_nxt = cap_word[STP_REG_W-1:0];
                end
                STP_SEL_TBL:
                begin
                    // past the last entry the load and table write are dropped; diag_clr still fires
                    if (pt_idx_r < PT_IW'(PT_ENTRIES))
                    begin
                        tbl_nxt = cap_word[STP_REG_W-1:0];
                        pt_accept = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            cfg0_r <= STP_CFG0_RST; // [R18]
            cfg1_r <= STP_CFG1_RST;
            run_r <= STP_RUN_RST;
            tbl_r <= STP_TBL_RST;
        end
        else if (clk_en)
        begin
            cfg0_r <= cfg0_nxt; // [R4]
            cfg1_r <= cfg1_nxt;
            run_r <= run_nxt;
            tbl_r <= tbl_nxt;
        end
    end

    // phase table loading; other writes or bad frames restart the run
    always_comb
    begin
        parity_bad = !(^cap_word[STP_PTP_BIT:0]);
        pt_idx_nxt = pt_idx_r;
        if (pt_accept)
        begin
            pt_idx_nxt = pt_idx_r + PT_IW'(1);
        end
        else if (frame == STP_FR_ERROR)
        begin
            pt_idx_nxt = '0;
        end
        else if (frame == STP_FR_WRITE && sel != STP_SEL_TBL)
        begin
            pt_idx_nxt = '0;
        end
        pt_wr_nxt = pt_accept;
        pt_addr_nxt = pt_accept ? pt_idx_r[PT_AW-1:0] : pt_addr_r;
        pt_data_nxt = pt_accept ? cap_word[STP_PT_DATA_W-1:0] : pt_data_r;
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            pt_idx_r <= '0;
            pt_wr_r <= 1'b0;
            pt_addr_r <= '0;
            pt_data_r <= '0;
        end
        else if (clk_en)
        begin
            pt_idx_r <= pt_idx_nxt;
            pt_wr_r <= pt_wr_nxt;
            pt_addr_r <= pt_addr_nxt;
            pt_data_r <= pt_data_nxt;
        end
    end

    // sticky fault flags: a new event beats a clear in the same cycle
    always_comb
    begin
        diag_clr = (frame == STP_FR_WRITE); // [R5]
        shared_evt = {thermal_warn_hi, thermal_warn_lo, overvoltage_flag,
                      undervoltage_flag, stall_flag, open_load_b,
                      open_load_a}; // [R14]
        shared_nxt = (diag_clr ? '0 : shared_r) | shared_evt;
        short_nxt = (diag_clr ? '0 : short_r) | short_flags; // [R15]
        // an errored frame leaves flags alone apart from the error bit
        xfer_err_nxt = (diag_clr ? 1'b0 : xfer_err_r)
                       | (frame == STP_FR_ERROR); // [R6]
        parity_err_nxt = (diag_clr ? 1'b0 : parity_err_r)
                         | (pt_accept && parity_bad);
        ff_nxt = (|shared_nxt) || (|short_nxt) || xfer_err_nxt
                 || parity_err_nxt; // [R19]
        angle_nxt = step_angle;
        diag_clear_nxt = diag_clr;
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            shared_r <= STP_SHARED_RST; // [R20]
            short_r <= STP_SHORT_RST;
            xfer_err_r <= 1'b0;
            parity_err_r <= 1'b0;
            ff_r <= 1'b1;
            angle_r <= '0;
            diag_clear_r <= 1'b0;
        end
        else if (clk_en)
        begin
            shared_r <= shared_nxt;
            short_r <= short_nxt;
            xfer_err_r <= xfer_err_nxt;
            parity_err_r <= parity_err_nxt;
            ff_r <= ff_nxt;
            angle_r <= angle_nxt;
            diag_clear_r <= diag_clear_nxt;
        end
    end

    // snapshot follows the flags only while both strobe samples are idle,
    // so the link sees static words for the whole frame
    always_comb
    begin
        word_short = {ff_r, shared_r, short_r}; // [R14] [R15]
        word_step = {ff_r, shared_r, STP_ANGLE_PAD, angle_r}; // [R16]
        snap_short_nxt = snap_short_r;
        snap_step_nxt = snap_step_r;
        if (strobe_s && strobe_d_r)
        begin
            snap_short_nxt = word_short;
            snap_step_nxt = word_step;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            snap_short_r <= {1'b1, STP_SHARED_RST, STP_SHORT_RST};
            snap_step_r <= {1'b1, STP_SHARED_RST, STP_ANGLE_PAD, 6'h00};
        end
        else if (clk_en)
        begin
            snap_short_r <= snap_short_nxt;
            snap_step_r <= snap_step_nxt;
        end
    end

    assign system_config = cfg0_r;
    assign diag_config = cfg1_r;
    assign motor_run_control = run_r;
    assign phase_table_load = tbl_r;
    assign pt_wr = pt_wr_r;
    assign pt_addr = pt_addr_r;
    assign pt_data = pt_data_r;
    assign diag_clear = diag_clear_r;
    assign fault_summary_flag = ff_r;

endmodule : stp_port

// [rtl/stp_sync.sv]
`timescale 1ns/10ps
module stp_sync
    import stp_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
)
(
    input logic clk,
    input logic rstn,
    input logic en,
    input logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // first stage feeds the second stage only
    always_comb
    begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            meta_r <= RST;
            q_r <= RST;
        end
        else if (en)
        begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule : stp_sync

// [tb/stp_master.sv]
`timescale 1ns/10ps
module stp_master
(
    output logic sck,
    output logic select_strobe_n,
    output logic serial_in,
    input logic serial_out
);
    initial
    begin
        sck = 1'b1;
        select_strobe_n = 1'b1;
        serial_in = 1'b0;
    end

    // sck idles high, so zero rises makes a poll
    task automatic xfer(input logic [15:0] w, input int n,
        output logic [15:0] rd, output logic ff);
        int k;
        rd = 16'h0000;
        select_strobe_n = 1'b0;
        #15;
        ff = serial_out;
        for (k = 0; k < n; k++)
        begin
            sck = 1'b0;
            serial_in = (k < 16) ? w[15 - k] : ~serial_in;
            #15;
            if (k < 16)
                rd[15 - k] = serial_out;
            sck = 1'b1;
            #15;
        end
        select_strobe_n = 1'b1;
        // released line must not keep the last bit
        serial_in = ~serial_in;
        #15;
    endtask : xfer

    // shared lines busy with another slave while our strobe stays high
    task automatic idle_clk(input int n);
        repeat (n)
        begin
            sck = 1'b0;
            serial_in = ~serial_in;
            #15;
            sck = 1'b1;
            #15;
        end
    endtask : idle_clk
endmodule : stp_master

// [tb/stp_port_assertions.sv]
`timescale 1ns/10ps
module stp_port_assertions
    import stp_pkg::*;
#(
    parameter int PT_ENTRIES = STP_PT_ENTRIES,
    localparam int PT_AW = $clog2(PT_ENTRIES)
)
(
    input logic mclk,
    input logic rstn,
    input logic clk_en,
    input logic select_strobe_n,
    input logic serial_out_oe,
    input logic [7:0] short_flags,
    input logic [13:0] system_config,
    input logic [13:0] diag_config,
    input logic [13:0] motor_run_control,
    input logic [13:0] phase_table_load,
    input logic pt_wr,
    input logic [PT_AW-1:0] pt_addr,
    input logic [5:0] pt_data,
    input logic diag_clear,
    input logic fault_summary_flag
);
    logic [55:0] regs;
    logic [PT_AW-1:0] last_addr_r;
    logic [PT_AW-1:0] last_addr_nxt;

    assign regs = {system_config, diag_config, motor_run_control,
        phase_table_load};

    always_comb
    begin
        last_addr_nxt = pt_wr ? pt_addr : last_addr_r;
    end

    always_ff @(posedge mclk)
    begin
        last_addr_r <= last_addr_nxt;
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // the strobe rise needs two sync stages before any write lands
    sequence strobe_settled;
        $past(select_strobe_n, 2);
    endsequence

    sequence clear_pulse;
        diag_clear ##1 !diag_clear;
    endsequence

    a_oe_follows_strobe: assert property (serial_out_oe == !select_strobe_n)
        else $error("serial_out_oe does not follow the strobe");
    a_reset_values: assert property (disable iff (1'b0) !rstn |=>
        regs == {STP_CFG0_RST, STP_CFG1_RST, STP_RUN_RST, STP_TBL_RST}
        && fault_summary_flag && !pt_wr && !diag_clear)
        else $error("power-on values wrong after reset");
    a_load_with_clear: assert property (regs != $past(regs) |-> diag_clear)
        else $error("register changed without a diagnostic clear");
    a_clear_after_rise: assert property (diag_clear |-> strobe_settled)
        else $error("write acted on before the strobe rose");
    a_clear_one_cycle: assert property (diag_clear && clk_en |-> clear_pulse)
        else $error("diag_clear is not a single pulse");
    a_table_entry: assert property (pt_wr |->
        diag_clear && pt_data == phase_table_load[5:0])
        else $error("table entry does not match the loaded word");
    a_table_step: assert property (pt_wr && pt_addr != '0 |->
        pt_addr == last_addr_r + 1'b1)
        else $error("table index did not advance by one");
    a_short_sets_flag: assert property (clk_en && |short_flags |=>
        fault_summary_flag)
        else $error("short event did not raise the summary flag");
    a_clk_en_freeze: assert property (!clk_en |=>
        $stable(regs) && $stable(fault_summary_flag))
        else $error("state moved while clk_en was low");
endmodule : stp_port_assertions

// [tb/test_stp_port.sv]
`timescale 1ns/10ps
module test_stp_port
    import stp_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn, clk_en, sck, select_strobe_n, serial_in;
    logic serial_out, serial_out_oe, pt_wr, diag_clear, fault_summary_flag;
    logic [6:0] shared_ev;
    logic [7:0] short_flags;
    logic [5:0] step_angle, pt_data;
    logic [3:0] pt_addr;
    logic [13:0] system_config, diag_config, motor_run_control;
    logic [13:0] phase_table_load;
    logic [15:0] rd;
    logic ff;
    int errors = 0;
    int n_checks = 0;

    always #2 mclk = ~mclk;

    stp_port i_dut (
        .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .sck(sck),
        .select_strobe_n(select_strobe_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .thermal_warn_hi(shared_ev[6]), .thermal_warn_lo(shared_ev[5]),
        .overvoltage_flag(shared_ev[4]), .undervoltage_flag(shared_ev[3]),
        .stall_flag(shared_ev[2]), .open_load_b(shared_ev[1]),
        .open_load_a(shared_ev[0]), .short_flags(short_flags),
        .step_angle(step_angle), .system_config(system_config),
        .diag_config(diag_config), .motor_run_control(motor_run_control),
        .phase_table_load(phase_table_load), .pt_wr(pt_wr),
        .pt_addr(pt_addr), .pt_data(pt_data), .diag_clear(diag_clear),
        .fault_summary_flag(fault_summary_flag)
    );

    stp_master i_mst (
        .sck(sck), .select_strobe_n(select_strobe_n),
        .serial_in(serial_in), .serial_out(serial_out)
    );

    task automatic results();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task automatic check(input string name, input logic [63:0] exp,
        input logic [63:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask : check

    task automatic pulse(input logic [6:0] s, input logic [7:0] f);
        @(negedge mclk);
        shared_ev = s;
        short_flags = f;
        @(negedge mclk);
        shared_ev = 7'h00;
        short_flags = 8'h00;
        repeat (4) @(negedge mclk);
    endtask : pulse

    task automatic wr_chk(input logic [15:0] w, input logic [15:0] exp);
        logic [13:0] got;
        i_mst.xfer(w, 16, rd, ff);
        repeat (8) @(negedge mclk);
        case (w[15:14])
            STP_SEL_CFG0: got = system_config;
            STP_SEL_CFG1: got = diag_config;
            STP_SEL_RUN: got = motor_run_control;
            default: got = phase_table_load;
        endcase
        check("read", {48'h0, exp}, {48'h0, rd});
        check("reg", {50'h0, w[13:0]}, {50'h0, got});
    endtask : wr_chk

    task automatic err_chk(input int n);
        i_mst.xfer(16'h0fff, n, rd, ff);
        repeat (8) @(negedge mclk);
        check("cfg0", 64'h1234, {50'h0, system_config});
        check("flag", 64'h1, {63'h0, fault_summary_flag});
    endtask : err_chk

    task automatic pt_chk(input logic [9:0] exp);
        check("table", {54'h0, exp}, {54'h0, pt_addr, pt_data});
    endtask : pt_chk

    initial
    begin
        rstn = 1'b0;
        clk_en = 1'b1;
        shared_ev = 7'h00;
        short_flags = 8'h00;
        step_angle = 6'h2a;
        repeat (12) @(negedge mclk);
        rstn = 1'b1;
        repeat (4) @(negedge mclk);
        check("reset", {8'h0, STP_CFG0_RST, STP_CFG1_RST, STP_RUN_RST,
            STP_TBL_RST}, {8'h0, system_config, diag_config,
            motor_run_control, phase_table_load});
        i_mst.xfer(16'h0000, 0, rd, ff);
        repeat (8) @(negedge mclk);
        check("poll", 64'h1, {63'h0, ff});
        check("flag", 64'h1, {63'h0, fault_summary_flag});
        wr_chk(16'h1234, 16'hffff);
        check("flag", 64'h0, {63'h0, fault_summary_flag});
        pulse(7'h55, 8'h00);
        wr_chk(16'h4abc, 16'hd52a);
        pulse(7'h2a, 8'h81);
        // traffic for another slave must not reach our edge count
        i_mst.idle_clk(5);
        wr_chk(16'h8555, 16'haa81);
        wr_chk(16'hc001, 16'h0000);
        pt_chk({4'h0, 6'h01});
        err_chk(17);
        wr_chk(16'hc043, 16'h8000);
        pt_chk({4'h0, 6'h03});
        err_chk(15);
        wr_chk(16'hc003, 16'h8000);
        pt_chk({4'h0, 6'h03});
        check("parity", 64'h1, {63'h0, fault_summary_flag});
        wr_chk(16'hc043, 16'h8000);
        pt_chk({4'h1, 6'h03});
        for (int i = 2; i < 16; i++)
        begin
            i_mst.xfer(16'hc001, 16, rd, ff);
            repeat (8) @(negedge mclk);
        end
        // table is full now, so this word must not land anywhere
        i_mst.xfer(16'hc07f, 16, rd, ff);
        repeat (8) @(negedge mclk);
        check("full", 64'h1, {50'h0, phase_table_load});
        pt_chk({4'hf, 6'h01});
        @(negedge mclk);
        clk_en = 1'b0;
        short_flags = 8'h10;
        repeat (5) @(negedge mclk);
        short_flags = 8'h00;
        clk_en = 1'b1;
        repeat (3) @(negedge mclk);
        // an event seen only while frozen must leave the flag low
        check("freeze", 64'h0, {63'h0, fault_summary_flag});
        results();
    end

    // under thirty frames of about half a microsecond each
    initial
    begin
        #50000;
        errors++;
        results();
    end
endmodule : test_stp_port

bind stp_port stp_port_assertions #(.PT_ENTRIES(PT_ENTRIES)) i_chk (
    .mclk(mclk), .rstn(rstn), .clk_en(clk_en),
    .select_strobe_n(select_strobe_n), .serial_out_oe(serial_out_oe),
    .short_flags(short_flags), .system_config(system_config),
    .diag_config(diag_config), .motor_run_control(motor_run_control),
    .phase_table_load(phase_table_load), .pt_wr(pt_wr),
    .pt_addr(pt_addr), .pt_data(pt_data), .diag_clear(diag_clear),
    .fault_summary_flag(fault_summary_flag)
);
